/* File: hdl/oflm_engine.sv */
/*
 * Frame loss measurement engine of an OAM endpoint: per-class loss
 * counters, LMM/LMR and CCM-LM field fill, sticky flags, PDU counts.
 * Assumes the frame pipeline presents one lookup per cycle on ref_clk
 * and applies the returned field writes one cycle later.
 */
// Summary of operation
// RQ1 - One shared loss counter set serves single- and dual-ended measurement.
// RQ2 - No mode select; PDU types seen decide the measurement type.
// RQ3 - Every loss PDU samples counters picked by the service class index.
// RQ4 - Synthetic loss PDUs still set their own receive sticky bits.
// RQ5 - LMM/LMR hardware enables; when off only statistics, frame unmodified.
// RQ6 - LMM/LMR bits gate PDU counts and data counting in loss counters.
// RQ7 - Tx LMM: TxFCf from tx loss counter, count tx LMM.
// RQ8 - Rx LMM: sticky, RxFCf from rx loss counter, count rx LMM.
// RQ9 - Loopback on: each rx LMM requests an LMR injection toward peer.
// RQ10 - Copy enables send every valid rx LMM or LMR to the CPU.
// RQ11 - Tx LMR: TxFCb from tx loss counter, count tx LMR.
// RQ12 - Rx LMR: sticky, sample rx counter as RxFCb, count rx LMR.
// RQ13 - Insert on: TLV offset 12 to 16, RxFCb after TxFCb, end zeroed.
// RQ14 - Software keeps CCM processing on while running dual-ended measure.
// RQ15 - CCM-LM hardware enable; off means plain CCM but sticky still set.
// RQ16 - CCM-LM bits gate PDU counts and data counting in loss counters.
// RQ17 - Injected valid CCM with any non-zero loss field is CCM-LM.
// RQ18 - Insert-next flag, by software or timer, makes next CCM a CCM-LM.
// RQ19 - Hardware clears insert-next once loss info went into a CCM.
// RQ20 - Tx CCM-LM: TxFCf from counter, TxFCb/RxFCb from stored registers.
// RQ21 - Rx CCM-LM: sticky, store TxFCf and rx counter, count rx PDU.
// RQ22 - Reserved update on: sampled RxFCf written after TxFCb on rx.
// RQ23 - Each count moves by one per qualifying frame, same lookup.
`timescale 1ns/100ps
module oflm_engine (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        lookup_valid,
  input  wire logic        lookup_tx,
  input  wire logic [2:0]  lookup_pdu_type,
  input  wire logic        lookup_pdu_ok,
  input  wire logic [2:0]  lookup_class,
  input  wire logic [31:0] lookup_txfcf,
  input  wire logic [31:0] lookup_rxfcf,
  input  wire logic [31:0] lookup_txfcb,
  input  wire logic        data_frame_valid,
  input  wire logic        data_frame_tx,
  input  wire logic [2:0]  data_frame_class,
  input  wire logic        loc_timer_expire,
  output logic             res_valid,
  output logic             res_tx_fwd_we,
  output logic      [31:0] res_tx_fwd,
  output logic             res_rx_fwd_we,
  output logic      [31:0] res_rx_fwd,
  output logic             res_tx_back_we,
  output logic      [31:0] res_tx_back,
  output logic             res_rx_back_we,
  output logic      [31:0] res_rx_back,
  output logic             res_post_we,
  output logic      [31:0] res_post,
  output logic             res_tlv_we,
  output logic      [7:0]  res_tlv_offset,
  output logic             res_end_tlv_zero,
  output logic             res_cpu_copy,
  output logic             res_inject_reply,
  output logic             res_ccm_lm
);
  // Bus and configuration state
  logic        wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [13:0] ctrl_reg, ctrl_next;
  logic [4:0]  sticky_reg, sticky_next;
  logic        insert_reg, insert_next;
  logic [31:0] msg_tx_reg, msg_tx_next, msg_rx_reg, msg_rx_next;
  logic [31:0] rep_tx_reg, rep_tx_next, rep_rx_reg, rep_rx_next;
  logic [31:0] stored_tx_reg, stored_tx_next;
  logic [31:0] stored_rx_reg, stored_rx_next;
  logic [31:0] tx_lm_reg [oflm_pkg::NUM_CLASSES];
  logic [31:0] tx_lm_next [oflm_pkg::NUM_CLASSES];
  logic [31:0] rx_lm_reg [oflm_pkg::NUM_CLASSES];
  logic [31:0] rx_lm_next [oflm_pkg::NUM_CLASSES];
  // Result state
  logic        rv_reg, rv_next;
  logic        tfw_reg, tfw_next, rfw_reg, rfw_next;
  logic        tbw_reg, tbw_next, rbw_reg, rbw_next;
  logic        pw_reg, pw_next, tlv_reg, tlv_next, ez_reg, ez_next;
  logic        cp_reg, cp_next, inj_reg, inj_next, cl_reg, cl_next;
  logic [31:0] tf_reg, tf_next, rf_reg, rf_next;
  logic [31:0] tb_reg, tb_next, rb_reg, rb_next, pv_reg, pv_next;
  logic [7:0]  to_reg, to_next;
  // Decode
  logic        req, bus_wr, lk, rx, tx;
  logic        is_msg, is_rep, is_ccm, ccm_lm;
  logic [31:0] tx_sel, rx_sel;
  logic        msg_data, rep_data, ccm_data;

  assign req    = avs_read | avs_write;
  assign bus_wr = avs_write & ~wait_reg;
  assign lk     = lookup_valid & lookup_pdu_ok;
  assign rx     = lk & ~lookup_tx;
  assign tx     = lk & lookup_tx;
  assign is_msg = lookup_pdu_type == oflm_pkg::PDU_LMM;
  assign is_rep = lookup_pdu_type == oflm_pkg::PDU_LMR;
  assign is_ccm = lookup_pdu_type == oflm_pkg::PDU_CCM;
  // Non-zero loss fields, or the insert flag on a tx CCM, mark a CCM as CCM-LM
  assign ccm_lm = is_ccm & ((lookup_tx & insert_reg) |             // RQ18
                  (|{lookup_txfcf, lookup_rxfcf, lookup_txfcb})); // RQ17
  assign tx_sel = tx_lm_reg[lookup_class];                        // RQ3
  assign rx_sel = rx_lm_reg[lookup_class];                        // RQ3
  assign msg_data = lk & is_msg & ctrl_reg[oflm_pkg::MSG_DATA_BIT];
  assign rep_data = lk & is_rep & ctrl_reg[oflm_pkg::REPLY_DATA_BIT];
  assign ccm_data = lk & ccm_lm & ctrl_reg[oflm_pkg::CCM_DATA_BIT];

  // Avalon slave: one wait cycle, then the access completes
  always_comb begin
    wait_next  = ~(req & wait_reg);
    rdata_next = rdata_reg;
    if (req & wait_reg) begin
      unique case (avs_address)
        oflm_pkg::CTRL_OFS:      rdata_next = {18'h0, ctrl_reg};
        oflm_pkg::STICKY_OFS:    rdata_next = {27'h0, sticky_reg};
        oflm_pkg::INSERT_OFS:    rdata_next = {31'h0, insert_reg};
        oflm_pkg::MSG_TX_OFS:    rdata_next = msg_tx_reg;
        oflm_pkg::MSG_RX_OFS:    rdata_next = msg_rx_reg;
        oflm_pkg::REPLY_TX_OFS:  rdata_next = rep_tx_reg;
        oflm_pkg::REPLY_RX_OFS:  rdata_next = rep_rx_reg;
        oflm_pkg::STORED_TX_OFS: rdata_next = stored_tx_reg;
        oflm_pkg::STORED_RX_OFS: rdata_next = stored_rx_reg;
        default:                 rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Configuration, sticky flags, insert flag, stored values, counts
  always_comb begin
    ctrl_next      = ctrl_reg;
    sticky_next    = sticky_reg;
    insert_next    = insert_reg;
    stored_tx_next = stored_tx_reg;
    stored_rx_next = stored_rx_reg;
    msg_tx_next    = msg_tx_reg;
    msg_rx_next    = msg_rx_reg;
    rep_tx_next    = rep_tx_reg;
    rep_rx_next    = rep_rx_reg;
    if (bus_wr && avs_address == oflm_pkg::CTRL_OFS) begin
      ctrl_next = avs_writedata[13:0];                        // RQ2
    end
    // Clear first so a same-cycle event set below wins
    if (bus_wr && avs_address == oflm_pkg::STICKY_OFS) begin
      sticky_next = sticky_reg & ~avs_writedata[4:0];
    end
    if (tx && ccm_lm && ctrl_reg[oflm_pkg::CCM_HW_BIT]) begin
      insert_next = 1'b0;                                     // RQ19
    end
    if ((bus_wr && avs_address == oflm_pkg::INSERT_OFS &&
         avs_writedata[0]) || loc_timer_expire) begin
      insert_next = 1'b1;                                     // RQ18
    end
    if (rx) begin
      if (is_msg) begin
        sticky_next[oflm_pkg::ST_MSG_BIT] = 1'b1;             // RQ8
      end
      if (is_rep) begin
        sticky_next[oflm_pkg::ST_REPLY_BIT] = 1'b1;           // RQ12
      end
      if (ccm_lm) begin
        sticky_next[oflm_pkg::ST_CCM_BIT] = 1'b1;             // RQ15
      end
      if (lookup_pdu_type == oflm_pkg::PDU_SLM) begin
        sticky_next[oflm_pkg::ST_SYN_M_BIT] = 1'b1;           // RQ4
      end
      if (lookup_pdu_type == oflm_pkg::PDU_SLR) begin
        sticky_next[oflm_pkg::ST_SYN_R_BIT] = 1'b1;           // RQ4
      end
    end
    if (lk && is_msg && ctrl_reg[oflm_pkg::MSG_PDU_CNT_BIT]) begin
      if (lookup_tx) begin
        msg_tx_next = msg_tx_reg + 32'h1;                     // RQ7 RQ23
      end else begin
        msg_rx_next = msg_rx_reg + 32'h1;                     // RQ8 RQ23
      end
    end
    if (lk && is_rep && ctrl_reg[oflm_pkg::REPLY_PDU_CNT_BIT]) begin
      if (lookup_tx) begin
        rep_tx_next = rep_tx_reg + 32'h1;                     // RQ11 RQ23
      end else begin
        rep_rx_next = rep_rx_reg + 32'h1;                     // RQ12 RQ23
      end
    end
    // CCM-LM counts share the LMM tx and LMR rx counts
    if (lk && ccm_lm && ctrl_reg[oflm_pkg::CCM_HW_BIT] &&
        ctrl_reg[oflm_pkg::CCM_PDU_CNT_BIT]) begin          // RQ16
      if (lookup_tx) begin
        msg_tx_next = msg_tx_reg + 32'h1;                     // RQ20 RQ23
      end else begin
        rep_rx_next = rep_rx_reg + 32'h1;                     // RQ21 RQ23
      end
    end
    if (rx && ccm_lm && ctrl_reg[oflm_pkg::CCM_HW_BIT]) begin
      stored_tx_next = lookup_txfcf;                          // RQ21
      stored_rx_next = rx_sel;                                // RQ21
    end
  end

  // Shared per-class loss counters, data frames plus optional PDUs
  always_comb begin
    for (int i = 0; i < oflm_pkg::NUM_CLASSES; i++) begin
      tx_lm_next[i] = tx_lm_reg[i];                           // RQ1
      rx_lm_next[i] = rx_lm_reg[i];                           // RQ1
      if (data_frame_valid && data_frame_class == 3'(i)) begin
        if (data_frame_tx) begin
          tx_lm_next[i] = tx_lm_next[i] + 32'h1;
        end else begin
          rx_lm_next[i] = rx_lm_next[i] + 32'h1;
        end
      end
      if ((msg_data || rep_data || ccm_data) &&
          lookup_class == 3'(i)) begin                        // RQ6 RQ16
        if (lookup_tx) begin
          tx_lm_next[i] = tx_lm_next[i] + 32'h1;
        end else begin
          rx_lm_next[i] = rx_lm_next[i] + 32'h1;
        end
      end
    end
  end

  // Lookup result: fields sampled before this lookup's own counting
  always_comb begin
    rv_next  = lookup_valid;
    tfw_next = 1'b0;
    rfw_next = 1'b0;
    tbw_next = 1'b0;
    rbw_next = 1'b0;
    pw_next  = 1'b0;
    tlv_next = 1'b0;
    ez_next  = 1'b0;
    cp_next  = 1'b0;
    inj_next = 1'b0;
    cl_next  = 1'b0;
    tf_next  = 32'h0000_0000;
    rf_next  = 32'h0000_0000;
    tb_next  = 32'h0000_0000;
    rb_next  = 32'h0000_0000;
    pv_next  = 32'h0000_0000;
    to_next  = oflm_pkg::REPLY_TLV_BASE;
    if (lk && is_msg) begin
      cp_next = rx & ctrl_reg[oflm_pkg::MSG_COPY_BIT];        // RQ10
      if (ctrl_reg[oflm_pkg::MSG_HW_BIT]) begin               // RQ5
        tfw_next = lookup_tx;                                 // RQ7
        tf_next  = tx_sel;                                    // RQ7
        rfw_next = ~lookup_tx;                                // RQ8
        rf_next  = rx_sel;                                    // RQ8
        inj_next = rx & ctrl_reg[oflm_pkg::LOOPBACK_BIT];     // RQ9
      end
    end
    if (lk && is_rep) begin
      cp_next = rx & ctrl_reg[oflm_pkg::REPLY_COPY_BIT];      // RQ10
      if (ctrl_reg[oflm_pkg::REPLY_HW_BIT]) begin             // RQ5
        tbw_next = lookup_tx;                                 // RQ11
        tb_next  = tx_sel;                                    // RQ11
        if (rx && ctrl_reg[oflm_pkg::REPLY_INSERT_BIT]) begin
          pw_next  = 1'b1;                                    // RQ13
          pv_next  = rx_sel;                                  // RQ12 RQ13
          tlv_next = 1'b1;                                    // RQ13
          to_next  = oflm_pkg::REPLY_TLV_EXT;                 // RQ13
          ez_next  = 1'b1;                                    // RQ13
        end
      end
    end
    // Dual-ended work relies on the CCM path staying enabled
    if (lk && ccm_lm && ctrl_reg[oflm_pkg::CCM_HW_BIT]) begin // RQ14 RQ15
      cl_next = 1'b1;
      if (lookup_tx) begin
        tfw_next = 1'b1;                                      // RQ20
        tf_next  = tx_sel;                                    // RQ20
        tbw_next = 1'b1;                                      // RQ20
        tb_next  = stored_tx_reg;                             // RQ20
        rbw_next = 1'b1;                                      // RQ20
        rb_next  = stored_rx_reg;                             // RQ20
      end else if (ctrl_reg[oflm_pkg::CCM_RSV_BIT]) begin
        pw_next = 1'b1;                                       // RQ22
        pv_next = rx_sel;                                     // RQ22
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wait_reg      <= 1'b1;
      rdata_reg     <= oflm_pkg::COUNT_RESET;
      ctrl_reg      <= oflm_pkg::CTRL_RESET;
      sticky_reg    <= oflm_pkg::STICKY_RESET;
      insert_reg    <= 1'b0;
      msg_tx_reg    <= oflm_pkg::COUNT_RESET;
      msg_rx_reg    <= oflm_pkg::COUNT_RESET;
      rep_tx_reg    <= oflm_pkg::COUNT_RESET;
      rep_rx_reg    <= oflm_pkg::COUNT_RESET;
      stored_tx_reg <= oflm_pkg::COUNT_RESET;
      stored_rx_reg <= oflm_pkg::COUNT_RESET;
      for (int i = 0; i < oflm_pkg::NUM_CLASSES; i++) begin
        tx_lm_reg[i] <= oflm_pkg::COUNT_RESET;
        rx_lm_reg[i] <= oflm_pkg::COUNT_RESET;
      end
      rv_reg  <= 1'b0;
      tfw_reg <= 1'b0;
      rfw_reg <= 1'b0;
      tbw_reg <= 1'b0;
      rbw_reg <= 1'b0;
      pw_reg  <= 1'b0;
      tlv_reg <= 1'b0;
      ez_reg  <= 1'b0;
      cp_reg  <= 1'b0;
      inj_reg <= 1'b0;
      cl_reg  <= 1'b0;
      tf_reg  <= oflm_pkg::COUNT_RESET;
      rf_reg  <= oflm_pkg::COUNT_RESET;
      tb_reg  <= oflm_pkg::COUNT_RESET;
      rb_reg  <= oflm_pkg::COUNT_RESET;
      pv_reg  <= oflm_pkg::COUNT_RESET;
      to_reg  <= oflm_pkg::REPLY_TLV_BASE;
    end else begin
      wait_reg      <= wait_next;
      rdata_reg     <= rdata_next;
      ctrl_reg      <= ctrl_next;
      sticky_reg    <= sticky_next;
      insert_reg    <= insert_next;
      msg_tx_reg    <= msg_tx_next;
      msg_rx_reg    <= msg_rx_next;
      rep_tx_reg    <= rep_tx_next;
      rep_rx_reg    <= rep_rx_next;
      stored_tx_reg <= stored_tx_next;
      stored_rx_reg <= stored_rx_next;
      tx_lm_reg     <= tx_lm_next;
      rx_lm_reg     <= rx_lm_next;
      rv_reg  <= rv_next;
      tfw_reg <= tfw_next;
      rfw_reg <= rfw_next;
      tbw_reg <= tbw_next;
      rbw_reg <= rbw_next;
      pw_reg  <= pw_next;
      tlv_reg <= tlv_next;
      ez_reg  <= ez_next;
      cp_reg  <= cp_next;
      inj_reg <= inj_next;
      cl_reg  <= cl_next;
      tf_reg  <= tf_next;
      rf_reg  <= rf_next;
      tb_reg  <= tb_next;
      rb_reg  <= rb_next;
      pv_reg  <= pv_next;
      to_reg  <= to_next;
    end
  end

  assign avs_readdata     = rdata_reg;
  assign avs_waitrequest  = wait_reg;
  assign res_valid        = rv_reg;
  assign res_tx_fwd_we    = tfw_reg;
  assign res_tx_fwd       = tf_reg;
  assign res_rx_fwd_we    = rfw_reg;
  assign res_rx_fwd       = rf_reg;
  assign res_tx_back_we   = tbw_reg;
  assign res_tx_back      = tb_reg;
  assign res_rx_back_we   = rbw_reg;
  assign res_rx_back      = rb_reg;
  assign res_post_we      = pw_reg;
  assign res_post         = pv_reg;
  assign res_tlv_we       = tlv_reg;
  assign res_tlv_offset   = to_reg;
  assign res_end_tlv_zero = ez_reg;
  assign res_cpu_copy     = cp_reg;
  assign res_inject_reply = inj_reg;
  assign res_ccm_lm       = cl_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_msg_tx_count;
    tx && is_msg && ctrl_reg[oflm_pkg::MSG_PDU_CNT_BIT]
      |=> msg_tx_reg == $past(msg_tx_reg) + 32'h1;
  endproperty
  a_msg_tx_count: assert property (p_msg_tx_count) // RQ7
    else $error("tx LMM count did not step by one");

  property p_msg_rx_field;
    rx && is_msg && ctrl_reg[oflm_pkg::MSG_HW_BIT]
      |=> res_rx_fwd_we && res_rx_fwd == $past(rx_sel) && !res_tx_fwd_we;
  endproperty
  a_msg_rx_field: assert property (p_msg_rx_field) // RQ8
    else $error("rx LMM RxFCf not filled from rx counter");

  property p_msg_sticky;
    rx && is_msg |=> sticky_reg[oflm_pkg::ST_MSG_BIT] [*2];
  endproperty
  a_msg_sticky: assert property (p_msg_sticky) // RQ8
    else $error("rx LMM sticky not held");

  property p_loopback;
    rx && is_msg && ctrl_reg[oflm_pkg::MSG_HW_BIT]
      |=> res_inject_reply == $past(ctrl_reg[oflm_pkg::LOOPBACK_BIT]);
  endproperty
  a_loopback: assert property (p_loopback) // RQ9
    else $error("loopback injection wrong");

  property p_reply_tx_field;
    tx && is_rep && ctrl_reg[oflm_pkg::REPLY_HW_BIT]
      |=> res_tx_back_we && res_tx_back == $past(tx_sel);
  endproperty
  a_reply_tx_field: assert property (p_reply_tx_field) // RQ11
    else $error("tx LMR TxFCb not filled");

  property p_reply_insert;
    rx && is_rep && ctrl_reg[oflm_pkg::REPLY_HW_BIT] &&
    ctrl_reg[oflm_pkg::REPLY_INSERT_BIT]
      |=> res_tlv_we && res_tlv_offset == oflm_pkg::REPLY_TLV_EXT &&
          res_end_tlv_zero &&
          res_post_we && res_post == $past(rx_sel);
  endproperty
  a_reply_insert: assert property (p_reply_insert) // RQ13
    else $error("rx LMR insertion incomplete");

  property p_no_modify;
    lk && is_msg && !ctrl_reg[oflm_pkg::MSG_HW_BIT]
      |=> !res_tx_fwd_we && !res_rx_fwd_we && !res_inject_reply;
  endproperty
  a_no_modify: assert property (p_no_modify) // RQ5
    else $error("LMM modified with hardware off");

  property p_insert_clear;
    tx && ccm_lm && ctrl_reg[oflm_pkg::CCM_HW_BIT] && !loc_timer_expire &&
    !(bus_wr && avs_address == oflm_pkg::INSERT_OFS)
      |=> !insert_reg && res_ccm_lm;
  endproperty
  a_insert_clear: assert property (p_insert_clear) // RQ19
    else $error("insert flag not cleared after insertion");

  property p_ccm_rx_store;
    rx && ccm_lm && ctrl_reg[oflm_pkg::CCM_HW_BIT]
      |=> stored_tx_reg == $past(lookup_txfcf) &&
          stored_rx_reg == $past(rx_sel);
  endproperty
  a_ccm_rx_store: assert property (p_ccm_rx_store) // RQ21
    else $error("rx CCM-LM values not stored");

  property p_ccm_off_sticky;
    rx && ccm_lm && !ctrl_reg[oflm_pkg::CCM_HW_BIT]
      |=> sticky_reg[oflm_pkg::ST_CCM_BIT] && !res_ccm_lm;
  endproperty
  a_ccm_off_sticky: assert property (p_ccm_off_sticky) // RQ15
    else $error("CCM-LM off handling wrong");

  property p_bus_answer;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer late");
endmodule : oflm_engine

/* File: hdl/oflm_pkg.sv */
/*
 * Constants for the OAM frame loss measurement block: register offsets,
 * control and sticky bit positions, PDU type codes and field figures.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
package oflm_pkg;
  // Register byte offsets
  localparam logic [5:0] CTRL_OFS        = 6'h00;
  localparam logic [5:0] STICKY_OFS      = 6'h04;
  localparam logic [5:0] INSERT_OFS      = 6'h08;
  localparam logic [5:0] MSG_TX_OFS      = 6'h0c;
  localparam logic [5:0] MSG_RX_OFS      = 6'h10;
  localparam logic [5:0] REPLY_TX_OFS    = 6'h14;
  localparam logic [5:0] REPLY_RX_OFS    = 6'h18;
  localparam logic [5:0] STORED_TX_OFS   = 6'h1c;
  localparam logic [5:0] STORED_RX_OFS   = 6'h20;
  // Control register bits
  localparam int MSG_HW_BIT        = 0;
  localparam int REPLY_HW_BIT      = 1;
  localparam int MSG_PDU_CNT_BIT   = 2;
  localparam int REPLY_PDU_CNT_BIT = 3;
  localparam int MSG_DATA_BIT      = 4;
  localparam int REPLY_DATA_BIT    = 5;
  localparam int LOOPBACK_BIT      = 6;
  localparam int MSG_COPY_BIT      = 7;
  localparam int REPLY_COPY_BIT    = 8;
  localparam int REPLY_INSERT_BIT  = 9;
  localparam int CCM_HW_BIT        = 10;
  localparam int CCM_PDU_CNT_BIT   = 11;
  localparam int CCM_DATA_BIT      = 12;
  localparam int CCM_RSV_BIT       = 13;
  localparam int CTRL_WIDTH        = 14;
  localparam logic [13:0] CTRL_RESET = 14'h0000;
  // Sticky register bits
  localparam int ST_MSG_BIT   = 0;
  localparam int ST_REPLY_BIT = 1;
  localparam int ST_CCM_BIT   = 2;
  localparam int ST_SYN_M_BIT = 3;
  localparam int ST_SYN_R_BIT = 4;
  localparam int STICKY_WIDTH = 5;
  localparam logic [4:0] STICKY_RESET = 5'h00;
  // PDU type codes on the lookup port
  localparam logic [2:0] PDU_OTHER = 3'h0;
  localparam logic [2:0] PDU_LMM   = 3'h1;
  localparam logic [2:0] PDU_LMR   = 3'h2;
  localparam logic [2:0] PDU_CCM   = 3'h3;
  localparam logic [2:0] PDU_SLM   = 3'h4;
  localparam logic [2:0] PDU_SLR   = 3'h5;
  // Frame figures
  localparam int          CNT_WIDTH      = 32;
  localparam int          NUM_CLASSES    = 8;
  localparam logic [7:0]  REPLY_TLV_BASE = 8'h0c;
  localparam logic [7:0]  REPLY_TLV_EXT  = 8'h10;
  localparam logic [31:0] COUNT_RESET    = 32'h0000_0000;
endpackage : oflm_pkg

/* File: verification/oflm_pipe_model.sv */
/*
 * Frame pipeline model: presents lookups, data frames, timer pulses.
 * Assumes one ref_clk domain; tasks are called from the bench.
 */
`timescale 1ns/100ps
module oflm_pipe_model (
  input  wire logic        ref_clk,
  output logic             lookup_valid,
  output logic             lookup_tx,
  output logic      [2:0]  lookup_pdu_type,
  output logic             lookup_pdu_ok,
  output logic      [2:0]  lookup_class,
  output logic      [31:0] lookup_txfcf,
  output logic      [31:0] lookup_rxfcf,
  output logic      [31:0] lookup_txfcb,
  output logic             data_frame_valid,
  output logic             data_frame_tx,
  output logic      [2:0]  data_frame_class,
  output logic             loc_timer_expire
);
  initial begin
    {lookup_valid, lookup_tx, lookup_pdu_type, lookup_pdu_ok} = 6'h00;
    {lookup_class, lookup_txfcf, lookup_rxfcf, lookup_txfcb} = '1;
    {data_frame_valid, data_frame_tx, data_frame_class} = 5'h00;
    loc_timer_expire = 1'b0;
  end
  task automatic send(input logic tx, input logic [2:0] ty,
                      input logic [2:0] cls, input logic [31:0] fcf);
    @(posedge ref_clk);
    lookup_valid    <= 1'b1;
    lookup_tx       <= tx;
    lookup_pdu_type <= ty;
    lookup_pdu_ok   <= 1'b1;
    lookup_class    <= cls;
    lookup_txfcf    <= fcf;
    {lookup_rxfcf, lookup_txfcb} <= 64'h0;
    @(posedge ref_clk);
    lookup_valid    <= 1'b0;
    lookup_pdu_ok   <= 1'b0;
    // Released fields inverted, stale values never match
    lookup_class    <= ~cls;
    lookup_txfcf    <= ~fcf;
    {lookup_rxfcf, lookup_txfcb} <= {~fcf, ~fcf};
  endtask : send
  task automatic frames(input logic tx, input logic [2:0] cls, input int n);
    @(posedge ref_clk);
    data_frame_valid <= 1'b1;
    data_frame_tx    <= tx;
    data_frame_class <= cls;
    repeat (n) @(posedge ref_clk);
    data_frame_valid <= 1'b0;
  endtask : frames
  task automatic expire();
    @(posedge ref_clk);
    loc_timer_expire <= 1'b1;
    @(posedge ref_clk);
    loc_timer_expire <= 1'b0;
  endtask : expire
endmodule : oflm_pipe_model

/* File: verification/tb_top.sv */
/*
 * Self-checking bench: Avalon-MM register access plus lookups.
 * Assumes the model above drives every pipeline input.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        lookup_valid, lookup_tx, lookup_pdu_ok, data_frame_valid;
  logic        data_frame_tx, loc_timer_expire, res_valid, res_ccm_lm;
  logic [2:0]  lookup_pdu_type, lookup_class, data_frame_class;
  logic [31:0] lookup_txfcf, lookup_rxfcf, lookup_txfcb;
  logic        res_tx_fwd_we, res_rx_fwd_we, res_tx_back_we, res_rx_back_we;
  logic        res_post_we, res_tlv_we, res_end_tlv_zero, res_cpu_copy;
  logic        res_inject_reply;
  logic [31:0] res_tx_fwd, res_rx_fwd, res_tx_back, res_rx_back, res_post;
  logic [7:0]  res_tlv_offset;
  int          n_errors, n_tests;
  oflm_engine     u_dut  (.*);
  oflm_pipe_model u_pipe (.*);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic close_out();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_errors++;
      close_out();
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : av
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    av(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask : rd
  task automatic look(input logic tx, input logic [2:0] ty, input logic [2:0] c,
                      input logic [31:0] fcf);
    u_pipe.send(tx, ty, c, fcf);
    @(negedge ref_clk);
  endtask : look
  initial begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    n_errors = 0;
    n_tests  = 0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(oflm_pkg::CTRL_OFS, 32'h0, "ctrl reset");
    rd(6'h3c, 32'h0, "unmapped");
    av(1'b1, oflm_pkg::CTRL_OFS, 32'h0000_2fcf);
    rd(oflm_pkg::CTRL_OFS, 32'h0000_2fcf, "ctrl");
    u_pipe.frames(1'b1, 3'h2, 3);
    u_pipe.frames(1'b0, 3'h2, 5);
    look(1'b1, oflm_pkg::PDU_LMM, 3'h2, 32'h0);
    `CHK("tx_fwd", {1'b1, 32'h3}, {res_tx_fwd_we, res_tx_fwd})
    look(1'b1, oflm_pkg::PDU_LMM, 3'h5, 32'h0);
    `CHK("class", {1'b1, 32'h0}, {res_tx_fwd_we, res_tx_fwd})
    look(1'b0, oflm_pkg::PDU_LMM, 3'h2, 32'h0);
    `CHK("rx_fwd", {4'hf, 32'h5}, {res_rx_fwd_we, res_inject_reply,
      res_cpu_copy, res_valid, res_rx_fwd})
    look(1'b1, oflm_pkg::PDU_LMR, 3'h2, 32'h0);
    `CHK("tx_back", {1'b1, 32'h3}, {res_tx_back_we, res_tx_back})
    look(1'b0, oflm_pkg::PDU_LMR, 3'h2, 32'h0);
    `CHK("insert", {4'hf, 8'h10, 32'h5}, {res_post_we, res_tlv_we,
      res_end_tlv_zero, res_cpu_copy, res_tlv_offset,
      res_post})
    look(1'b0, oflm_pkg::PDU_CCM, 3'h2, 32'h1234);
    `CHK("ccm rx", {2'h3, 32'h5}, {res_ccm_lm, res_post_we, res_post})
    rd(oflm_pkg::STORED_TX_OFS, 32'h1234, "stored tx");
    rd(oflm_pkg::STORED_RX_OFS, 32'h5, "stored rx");
    for (int k = 0; k < 2; k++) begin
      // Software set first, timer pulse second
      if (k == 0) av(1'b1, oflm_pkg::INSERT_OFS, 32'h1);
      else u_pipe.expire();
      look(1'b1, oflm_pkg::PDU_CCM, 3'h2, 32'h0);
      `CHK("ccm tx", {2'h3, 32'h3, 32'h1234, 32'h5}, {res_ccm_lm,
        res_rx_back_we, res_tx_fwd, res_tx_back, res_rx_back})
      rd(oflm_pkg::INSERT_OFS, 32'h0, "insert flag");
    end
    look(1'b1, oflm_pkg::PDU_CCM, 3'h2, 32'h0);
    `CHK("plain ccm", 1'b0, res_ccm_lm)
    look(1'b0, oflm_pkg::PDU_SLM, 3'h2, 32'h0);
    rd(oflm_pkg::STICKY_OFS, 32'h0f, "sticky");
    av(1'b1, oflm_pkg::STICKY_OFS, 32'h1f);
    rd(oflm_pkg::STICKY_OFS, 32'h0, "sticky clear");
    rd(oflm_pkg::MSG_TX_OFS, 32'h4, "msg tx");
    rd(oflm_pkg::MSG_RX_OFS, 32'h1, "msg rx");
    rd(oflm_pkg::REPLY_TX_OFS, 32'h1, "reply tx");
    rd(oflm_pkg::REPLY_RX_OFS, 32'h2, "reply rx");
    av(1'b1, oflm_pkg::CTRL_OFS, 32'h0000_2fce);
    look(1'b0, oflm_pkg::PDU_LMM, 3'h2, 32'h0);
    `CHK("hw off", 2'h0, {res_rx_fwd_we, res_inject_reply})
    rd(oflm_pkg::MSG_RX_OFS, 32'h2, "stats only");
    av(1'b1, oflm_pkg::CTRL_OFS, 32'h0);
    look(1'b0, oflm_pkg::PDU_LMM, 3'h2, 32'h0);
    rd(oflm_pkg::MSG_RX_OFS, 32'h2, "count off");
    av(1'b1, oflm_pkg::CTRL_OFS, 32'h0000_1011);
    look(1'b1, oflm_pkg::PDU_LMM, 3'h2, 32'h0);
    look(1'b1, oflm_pkg::PDU_LMM, 3'h2, 32'h0);
    `CHK("data cnt", {1'b1, 32'h4}, {res_tx_fwd_we, res_tx_fwd})
    look(1'b0, oflm_pkg::PDU_CCM, 3'h2, 32'h1);
    `CHK("ccm off", 2'h0, {res_ccm_lm, res_post_we})
    look(1'b0, oflm_pkg::PDU_LMM, 3'h2, 32'h0);
    `CHK("ccm data", {1'b1, 32'h6}, {res_rx_fwd_we, res_rx_fwd})
    rd(oflm_pkg::STICKY_OFS, 32'h5, "ccm off sticky");
    close_out();
  end
endmodule : tb_top
